// ==== swr_map.vh ====
// Constants for the single-wire ROM command layer
`ifndef SWR_MAP_VH
`define SWR_MAP_VH
`define SWR_CMD_READ_ID 8'h33
`define SWR_CMD_MATCH 8'h55
`define SWR_CMD_SEARCH 8'hF0
`define SWR_CMD_SKIP 8'hCC
`define SWR_CMD_RESUME 8'hA5
`define SWR_CMD_OD_SKIP 8'h3C
`define SWR_CMD_OD_MATCH 8'h69
`define SWR_CLK_MHZ 40
`define SWR_RST_LONG_US 480
`define SWR_RST_STD_US 480
`define SWR_RST_OD_US 48
`define SWR_PDH_STD_US 30
`define SWR_PDH_OD_US 3
`define SWR_PDL_STD_US 120
`define SWR_PDL_OD_US 12
`define SWR_SAMP_STD_US 30
`define SWR_SAMP_OD_US 3
`define SWR_RD0_STD_US 30
`define SWR_RD0_OD_US 3
`define SWR_REH_STD_US 2
`define SWR_REH_OD_US 1
`define SWR_CNT_W 15
`endif

// ==== swr_crc8.v ====
// Identity CRC-8 engine, one bit per cycle
`timescale 1ns/1ps
module swr_crc8 (
    input wire clk_i,
    input wire reset_n_i,
    input wire clear_i,
    input wire bit_valid_i,
    input wire bit_i,
    output reg [7:0] crc_o
);
    wire fb;
    assign fb = crc_o[0] ^ bit_i;
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            crc_o <= 8'h00;
        end else if (clear_i) begin
            crc_o <= 8'h00;
        end else if (bit_valid_i) begin
            // Reflected x^8+x^5+x^4+1
            crc_o <= {fb, crc_o[7:5], crc_o[4] ^ fb, crc_o[3] ^ fb, crc_o[2:1]};
        end
    end
endmodule // swr_crc8

// ==== swr_rom_layer.v ====
// Single-wire bus ROM command layer with slot timing and presence
`timescale 1ns/1ps
`include "swr_map.vh"
module swr_rom_layer (
    input wire clk_i,
    input wire reset_n_i,
    input wire line_i,
    output wire line_o,
    output wire line_oe_n_o,
    input wire [55:0] identity_i,
    output reg function_start_o,
    output wire overdrive_flag_o,
    output wire resume_flag_o
);
    function [14:0] cyc;
        input integer us;
        integer full;
        begin
            full = us * `SWR_CLK_MHZ;
            // Longest span fits 15 bits, so the cut is safe
            cyc = full[14:0];
        end
    endfunction
    localparam ST_IDLE = 3'd0, ST_PDH = 3'd1, ST_PDL = 3'd2, ST_CMD = 3'd3;
    localparam ST_SEND = 3'd4, ST_MATCH = 3'd5, ST_SEARCH = 3'd6, ST_FUNC = 3'd7;
    reg s1_reg, s2_reg, prev_reg;
    reg [2:0] state_reg;
    reg [14:0] low_reg, cnt_reg, reh_reg;
    reg in_slot_reg, drive_reg, od_reg, rc_reg, od_pend_reg;
    reg [7:0] cmd_reg;
    reg [3:0] cbit_reg;
    reg [5:0] idx_reg;
    reg [1:0] phase_reg;
    reg slot_done_reg;
    reg ok_reg;
    wire [7:0] crc;
    wire [63:0] ident;
    assign ident = {crc, identity_i};
    wire ser_bit = ident[idx_reg];
    wire [14:0] t_samp = od_reg ? cyc(`SWR_SAMP_OD_US) : cyc(`SWR_SAMP_STD_US);
    wire [14:0] t_rd0 = od_reg ? cyc(`SWR_RD0_OD_US) : cyc(`SWR_RD0_STD_US);
    wire [14:0] t_reh = od_reg ? cyc(`SWR_REH_OD_US) : cyc(`SWR_REH_STD_US);
    wire [14:0] t_rst = od_reg ? cyc(`SWR_RST_OD_US) : cyc(`SWR_RST_STD_US);
    wire fall = prev_reg & ~s2_reg;
    wire rise = ~prev_reg & s2_reg;
    // Identity bits feed CRC once after reset, so CRC is valid before commands
    reg [5:0] crc_idx_reg;
    wire crc_run = crc_idx_reg < 6'd56;
    swr_crc8 u_crc (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .clear_i(1'b0),
        .bit_valid_i(crc_run),
        .bit_i(identity_i[crc_idx_reg]),
        .crc_o(crc)
    );
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            crc_idx_reg <= 6'd0;
        end else if (crc_run) begin
            crc_idx_reg <= crc_idx_reg + 6'd1;
        end
    end
    // Read slot: device wants to send a bit
    wire send_bit = (state_reg == ST_SEND) ? ser_bit :
                    (phase_reg == 2'd0) ? ser_bit : ~ser_bit;
    wire is_read = (state_reg == ST_SEND) ||
                   (state_reg == ST_SEARCH && phase_reg != 2'd2);
    assign line_o = 1'b0;
    assign line_oe_n_o = ~drive_reg;
    assign overdrive_flag_o = od_reg;
    assign resume_flag_o = rc_reg;
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            prev_reg <= 1'b1;
        end else begin
            s1_reg <= line_i;
            s2_reg <= s1_reg;
            prev_reg <= s2_reg;
        end
    end
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg <= ST_IDLE;
            low_reg <= 15'd0;
            cnt_reg <= 15'd0;
            reh_reg <= 15'd0;
            in_slot_reg <= 1'b0;
            drive_reg <= 1'b0;
            od_reg <= 1'b0;
            rc_reg <= 1'b0;
            od_pend_reg <= 1'b0;
            cmd_reg <= 8'h00;
            cbit_reg <= 4'd0;
            idx_reg <= 6'd0;
            phase_reg <= 2'd0;
            slot_done_reg <= 1'b0;
            ok_reg <= 1'b0;
            function_start_o <= 1'b0;
        end else begin
            function_start_o <= 1'b0;
            low_reg <= s2_reg ? 15'd0 : (low_reg == 15'h7FFF ? low_reg : low_reg + 15'd1);
            if (reh_reg != 15'd0) begin
                reh_reg <= reh_reg - 15'd1;
            end
            if (rise && !drive_reg) begin
                if (low_reg >= cyc(`SWR_RST_LONG_US)) begin
                    od_reg <= 1'b0;
                end
                // Short reset keeps speed; mid-range left as is
                if (low_reg >= t_rst || (od_reg && low_reg >= cyc(`SWR_RST_OD_US))) begin
                    state_reg <= ST_PDH;
                    cnt_reg <= 15'd0;
                    in_slot_reg <= 1'b0;
                end else begin
                    reh_reg <= t_reh;
                end
            end
            case (state_reg)
                ST_IDLE: begin
                end
                ST_PDH: begin
                    cnt_reg <= cnt_reg + 15'd1;
                    if (cnt_reg >= (od_reg ? cyc(`SWR_PDH_OD_US) : cyc(`SWR_PDH_STD_US))) begin
                        drive_reg <= 1'b1;
                        cnt_reg <= 15'd0;
                        state_reg <= ST_PDL;
                    end
                end
                ST_PDL: begin
                    cnt_reg <= cnt_reg + 15'd1;
                    if (cnt_reg >= (od_reg ? cyc(`SWR_PDL_OD_US) : cyc(`SWR_PDL_STD_US))) begin
                        drive_reg <= 1'b0;
                        state_reg <= ST_CMD;
                        cbit_reg <= 4'd0;
                        cmd_reg <= 8'h00;
                    end
                end
                ST_FUNC: begin
                end
                default: begin
                    // Slot engine: falls inside holdoff are glitches
                    if (fall && reh_reg == 15'd0 && !in_slot_reg) begin
                        in_slot_reg <= 1'b1;
                        cnt_reg <= 15'd0;
                        if (is_read && !send_bit) begin
                            drive_reg <= 1'b1;
                        end
                    end else if (fall && reh_reg != 15'd0) begin
                        reh_reg <= t_reh;
                    end
                    slot_done_reg <= 1'b0;
                    if (in_slot_reg) begin
                        cnt_reg <= cnt_reg + 15'd1;
                        if (cnt_reg == t_rd0) begin
                            drive_reg <= 1'b0;
                        end
                        if (cnt_reg == t_samp) begin
                            in_slot_reg <= 1'b0;
                            slot_done_reg <= 1'b1;
                            case (state_reg)
                                ST_CMD: begin
                                    cmd_reg <= {s2_reg, cmd_reg[7:1]};
                                    cbit_reg <= cbit_reg + 4'd1;
                                    if (cbit_reg == 4'd7) begin
                                        idx_reg <= 6'd0;
                                        phase_reg <= 2'd0;
                                        ok_reg <= 1'b1;
                                        // Stale pending speed must not leak into a plain match
                                        od_pend_reg <= 1'b0;
                                        case ({s2_reg, cmd_reg[7:1]})
                                            `SWR_CMD_READ_ID: state_reg <= ST_SEND;
                                            `SWR_CMD_MATCH: state_reg <= ST_MATCH;
                                            `SWR_CMD_OD_MATCH: begin
                                                state_reg <= ST_MATCH;
                                                od_pend_reg <= 1'b1;
                                            end
                                            `SWR_CMD_SEARCH: state_reg <= ST_SEARCH;
                                            `SWR_CMD_SKIP: begin
                                                state_reg <= ST_FUNC;
                                                function_start_o <= 1'b1;
                                                rc_reg <= 1'b0;
                                            end
                                            `SWR_CMD_OD_SKIP: begin
                                                od_reg <= 1'b1;
                                                state_reg <= ST_FUNC;
                                                function_start_o <= 1'b1;
                                                rc_reg <= 1'b0;
                                            end
                                            `SWR_CMD_RESUME: begin
                                                state_reg <= rc_reg ? ST_FUNC : ST_IDLE;
                                                function_start_o <= rc_reg;
                                            end
                                            default: state_reg <= ST_IDLE;
                                        endcase
                                    end
                                end
                                ST_SEND: begin
                                    idx_reg <= idx_reg + 6'd1;
                                    if (idx_reg == 6'd63) begin
                                        state_reg <= ST_FUNC;
                                        function_start_o <= 1'b1;
                                    end
                                end
                                ST_MATCH: begin
                                    if (od_pend_reg && idx_reg == 6'd0) begin
                                        od_reg <= 1'b1;
                                    end
                                    if (s2_reg != ser_bit) begin
                                        ok_reg <= 1'b0;
                                    end
                                    idx_reg <= idx_reg + 6'd1;
                                    if (idx_reg == 6'd63) begin
                                        od_pend_reg <= 1'b0;
                                        if (ok_reg && s2_reg == ser_bit) begin
                                            rc_reg <= 1'b1;
                                            state_reg <= ST_FUNC;
                                            function_start_o <= 1'b1;
                                        end else begin
                                            rc_reg <= 1'b0;
                                            state_reg <= ST_IDLE;
                                        end
                                    end
                                end
                                default: begin
                                    phase_reg <= (phase_reg == 2'd2) ? 2'd0 : phase_reg + 2'd1;
                                    if (phase_reg == 2'd2) begin
                                        idx_reg <= idx_reg + 6'd1;
                                        if (s2_reg != ser_bit) begin
                                            rc_reg <= 1'b0;
                                            state_reg <= ST_IDLE;
                                        end else if (idx_reg == 6'd63) begin
                                            rc_reg <= 1'b1;
                                            state_reg <= ST_FUNC;
                                            function_start_o <= 1'b1;
                                        end
                                    end
                                end
                            endcase
                        end
                    end
                end
            endcase
        end
    end
endmodule // swr_rom_layer

// ==== swr_host_model.sv ====
// Bus controller model on the shared open-drain line
`timescale 1ns/1ps
module swr_host_model (
    input wire clk_i,
    input wire dev_oe_n_i,
    output wire line_o
);
    reg pull_reg = 1'b0;
    reg fast_reg = 1'b0;
    reg glitch_reg = 1'b0;
    // Pull-up wins unless a party pulls low
    assign line_o = !(pull_reg || dev_oe_n_i === 1'b0);
    task automatic hold(input integer n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic bus_reset(input bit lng, output bit seen);
        pull_reg <= 1'b1;
        hold(lng ? 19400 : 2000);
        pull_reg <= 1'b0;
        if (lng) fast_reg = 1'b0;
        hold(fast_reg ? 300 : 2800);
        seen = !line_o;
        hold(fast_reg ? 400 : 3400);
    endtask
    task automatic write_bit(input bit b);
        integer lo;
        lo = b ? (fast_reg ? 20 : 100) : (fast_reg ? 130 : 1240);
        pull_reg <= 1'b1;
        hold(lo);
        pull_reg <= 1'b0;
        // Short dip inside holdoff must not start a slot
        if (glitch_reg) begin
            hold(10);
            pull_reg <= 1'b1;
            hold(8);
            pull_reg <= 1'b0;
            glitch_reg = 1'b0;
        end
        hold((fast_reg ? 180 : 1360) - lo);
    endtask
    task automatic write_byte(input [7:0] v);
        integer i;
        for (i = 0; i < 8; i = i + 1) write_bit(v[i]);
    endtask
    task automatic read_bit(output bit b);
        pull_reg <= 1'b1;
        hold(fast_reg ? 20 : 100);
        pull_reg <= 1'b0;
        hold(fast_reg ? 60 : 500);
        b = line_o;
        hold(fast_reg ? 100 : 760);
    endtask
endmodule // swr_host_model

// ==== swr_rom_layer_assertions.sv ====
// Port checks for the ROM command layer
`timescale 1ns/1ps
module swr_rom_layer_assertions (
    input wire clk_i,
    input wire reset_n_i,
    input wire line_i,
    input wire line_o,
    input wire line_oe_n_o,
    input wire [55:0] identity_i,
    input wire function_start_o,
    input wire overdrive_flag_o,
    input wire resume_flag_o
);
    reg [14:0] low_cnt_reg;
    reg [14:0] last_low_reg;
    reg [12:0] pull_cnt_reg;
    reg [1:0] fs_hist_reg;
    reg [10:0] pres_cnt_reg;
    reg pres_arm_reg;
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            low_cnt_reg <= 15'h0000;
            last_low_reg <= 15'h0000;
            pull_cnt_reg <= 13'h0000;
            fs_hist_reg <= 2'h0;
            pres_cnt_reg <= 11'h000;
            pres_arm_reg <= 1'b0;
        end else begin
            // Counter stands in for a long delay range after a long reset
            if (line_i && low_cnt_reg > 15'h4B00) begin
                pres_arm_reg <= 1'b1;
                pres_cnt_reg <= 11'h000;
            end else if (pres_arm_reg) begin
                pres_arm_reg <= line_oe_n_o;
                pres_cnt_reg <= pres_cnt_reg + 11'h001;
            end
            low_cnt_reg <= line_i ? 15'h0000 : low_cnt_reg + 15'h0001;
            if (line_i && low_cnt_reg != 15'h0000) last_low_reg <= low_cnt_reg;
            pull_cnt_reg <= line_oe_n_o ? 13'h0000 : pull_cnt_reg + 13'h0001;
            fs_hist_reg <= {fs_hist_reg[0], function_start_o};
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    open_drain_a: assert property (line_o == 1'b0)
        else $error("data output not low");
    fs_pulse_a: assert property (function_start_o |=> !function_start_o)
        else $error("start pulse too long");
    od_clear_a: assert property ($fell(overdrive_flag_o) |->
        low_cnt_reg >= 15'h4A38 || last_low_reg >= 15'h4A38) else $error("speed lost early");
    rc_set_a: assert property ($rose(resume_flag_o) |->
        ##[0:2] (function_start_o || fs_hist_reg != 2'h0)) else $error("resume set alone");
    pull_len_a: assert property ($rose(line_oe_n_o) |-> pull_cnt_reg inside
        {[13'h006E:13'h0082], [13'h01D6:13'h01EA], [13'h04A6:13'h04BA], [13'h12B6:13'h12CA]})
        else $error("pull length wrong");
    fs_idle_a: assert property (function_start_o |-> line_oe_n_o)
        else $error("start while pulling");
    od_rise_a: assert property ($rose(overdrive_flag_o) |-> line_oe_n_o)
        else $error("speed set while pulling");
    presence_a: assert property (pres_arm_reg |-> pres_cnt_reg <= 11'h4EC &&
        (line_oe_n_o || pres_cnt_reg >= 11'h47E)) else $error("no presence");
    cover property ($rose(overdrive_flag_o));
    cover property ($fell(overdrive_flag_o));
    cover property ($rose(resume_flag_o));
endmodule // swr_rom_layer_assertions

// ==== tb.sv ====
// Self-checking bench for the ROM command layer
`timescale 1ns/1ps
module tb;
    localparam [55:0] ID_BITS = 56'h5AC317E8649B2D; // Arbitrary strap value
    reg clk_i = 1'b0;
    reg reset_n_i = 1'b0;
    wire line, line_o, oe_n, od_flag, rc_flag, fstart;
    integer err_count = 0;
    integer n_checks = 0;
    integer fs_cnt = 0;
    reg [63:0] id_full;
    bit pres;
    always #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) if (fstart === 1'b1) fs_cnt <= fs_cnt + 1;
    swr_host_model host (.clk_i(clk_i), .dev_oe_n_i(oe_n), .line_o(line));
    swr_rom_layer dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .line_i(line), .line_o(line_o),
        .line_oe_n_o(oe_n), .identity_i(ID_BITS), .function_start_o(fstart),
        .overdrive_flag_o(od_flag), .resume_flag_o(rc_flag));
    function automatic [7:0] crc8(input [55:0] d);
        integer i;
        crc8 = 8'h00;
        for (i = 0; i < 56; i = i + 1) crc8 = (crc8 >> 1) ^ ((crc8[0] ^ d[i]) ? 8'h8C : 8'h00);
    endfunction
    task automatic chk(input [63:0] got, input [63:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmd(input bit lng, input [7:0] c);
        host.bus_reset(lng, pres);
        chk(pres, 1);
        host.write_byte(c);
    endtask
    task automatic t_od_skip;
        integer f;
        f = fs_cnt;
        chk(od_flag, 0);
        cmd(1'b1, 8'h3C);
        chk(od_flag, 1);
        chk(fs_cnt - f, 1);
        host.fast_reg = 1'b1;
    endtask
    task automatic t_read_id;
        integer i;
        bit b;
        reg [63:0] got;
        cmd(1'b0, 8'h33);
        chk(od_flag, 1);
        for (i = 0; i < 64; i = i + 1) begin
            host.read_bit(b);
            got[i] = b;
        end
        chk(got, id_full);
    endtask
    task automatic t_match;
        integer i, f;
        f = fs_cnt;
        cmd(1'b0, 8'h55);
        for (i = 0; i < 64; i = i + 1) host.write_bit(id_full[i]);
        chk(fs_cnt - f, 1);
        chk(rc_flag, 1);
    endtask
    task automatic t_resume(input bit ok);
        integer f;
        f = fs_cnt;
        cmd(1'b0, 8'hA5);
        chk(fs_cnt - f, ok);
    endtask
    task automatic t_search;
        integer i;
        bit t, c;
        cmd(1'b0, 8'hF0);
        for (i = 0; i < 4; i = i + 1) begin
            host.read_bit(t);
            host.read_bit(c);
            chk({t, c}, (i < 3) ? {id_full[i], ~id_full[i]} : 2'b11);
            // Third pass picks the other branch on purpose
            host.write_bit((t == c) ? 1'b0 : ((i == 2) ? ~t : t));
        end
        chk(rc_flag, 0);
    endtask
    task automatic t_od_match_miss;
        integer i, f;
        f = fs_cnt;
        cmd(1'b0, 8'h69);
        for (i = 0; i < 64; i = i + 1) host.write_bit(id_full[i] ^ (i == 0));
        chk(fs_cnt - f, 0);
        chk(od_flag, 1);
    endtask
    task automatic t_skip;
        integer f;
        f = fs_cnt;
        host.glitch_reg = 1'b1;
        cmd(1'b0, 8'hCC);
        chk(fs_cnt - f, 1);
        chk(rc_flag, 0);
    endtask
    task automatic t_long_reset;
        host.bus_reset(1'b1, pres);
        chk(pres, 1);
        chk(od_flag, 0);
    endtask
    task automatic give_verdict;
        $display("checks=%0d errors=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        id_full = {crc8(ID_BITS), ID_BITS};
        repeat (20) @(posedge clk_i);
        reset_n_i <= 1'b1;
        repeat (100) @(posedge clk_i);
        t_od_skip;
        t_read_id;
        t_match;
        t_resume(1'b1);
        t_search;
        t_od_match_miss;
        t_skip;
        t_resume(1'b0);
        t_long_reset;
        give_verdict;
    end
    // Run needs about 128k cycles; two long resets dominate
    initial begin
        repeat (150000) @(posedge clk_i);
        err_count = err_count + 1;
        give_verdict;
    end
endmodule // tb
bind swr_rom_layer swr_rom_layer_assertions chk_u (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .line_i(line_i), .line_o(line_o), .line_oe_n_o(line_oe_n_o), .identity_i(identity_i),
    .function_start_o(function_start_o), .overdrive_flag_o(overdrive_flag_o),
    .resume_flag_o(resume_flag_o));
